// File: logic/gpmux_cfg.svh
// Purpose: constants for the pin function multiplexer
// Assumes: included by the package and the top module
// Notes: register indices are word indices; byte address is four times
`ifndef GPMUX_CFG_SVH
`define GPMUX_CFG_SVH

// pin count and pin positions in the pin vectors
`define GPMUX_NPINS 11
`define GPMUX_NLINES 16
`define GPMUX_PIN_B5 8
`define GPMUX_PIN_B6 9
`define GPMUX_PIN_B7 10
// line offset of group b pins for key return and scan lines
`define GPMUX_B_LINE_OFS 5

// register indices (byte address = 4 * index)
`define GPMUX_IDX_A76 8'h50
`define GPMUX_IDX_A54 8'h51
`define GPMUX_IDX_A32 8'h52
`define GPMUX_IDX_A10 8'h53
`define GPMUX_IDX_B76 8'h54
`define GPMUX_IDX_B54 8'h55
`define GPMUX_IDX_OUTA 8'h60
`define GPMUX_IDX_OUTB 8'h61
`define GPMUX_IDX_INA 8'h62
`define GPMUX_IDX_INB 8'h63
`define GPMUX_NMODE 6

// field positions inside a mode register
`define GPMUX_HI_LSB 4
`define GPMUX_LO_LSB 0
`define GPMUX_HI_SEL 7
`define GPMUX_LO_SEL 3
// group b pins b7..b5 sit in bits 7..5 of the b data registers
`define GPMUX_B_DATA_LSB 5

// reset values and writable-bit masks
`define GPMUX_MODE_RST 8'h00
`define GPMUX_OUT_RST 11'h000
`define GPMUX_WMASK_A76 8'h7f
`define GPMUX_WMASK_A10 8'h77
`define GPMUX_WMASK_B76 8'hf7
`define GPMUX_WMASK_FULL 8'hff

// irq line numbers
`define GPMUX_IRQ_A7_B6 4'ha
`define GPMUX_IRQ_A6_CLR 4'hb
`define GPMUX_IRQ_A6_SET 4'h3
`define GPMUX_IRQ_A5_CLR 4'hc
`define GPMUX_IRQ_A5_SET 4'h4
`define GPMUX_IRQ_A4_CLR 4'hd
`define GPMUX_IRQ_A4_SET 4'h5
`define GPMUX_IRQ_A3_CLR 4'he
`define GPMUX_IRQ_A3_SET 4'h6
`define GPMUX_IRQ_A2_CLR 4'hf
`define GPMUX_IRQ_A2_SET 4'h7
`define GPMUX_IRQ_B7_CLR 4'h9
`define GPMUX_IRQ_B7_SET 4'h1
`define GPMUX_IRQ_B5_CLR 4'hb
`define GPMUX_IRQ_B5_SET 4'h3

`endif

// File: logic/gpmux_pkg.sv
// Purpose: types for the pin function multiplexer
// Assumes: gpmux_cfg.svh defines pin and line counts
// Notes: function codes are the raw 3-bit field values
package gpmux_pkg;
`include "gpmux_cfg.svh"

    // one bit per multiplexed pin: a0..a7, b5, b6, b7
    typedef logic [`GPMUX_NPINS-1:0] gpmux_pins_t;
    // one bit per irq, key return or scan line
    typedef logic [`GPMUX_NLINES-1:0] gpmux_lines_t;
    // raw 3-bit function code of one pin
    typedef enum logic [2:0] {
        GPMUX_CODE_GPIN = 3'h0,
        GPMUX_CODE_IRQ = 3'h1,
        GPMUX_CODE_ALT = 3'h2,
        GPMUX_CODE_KEYIN = 3'h3,
        GPMUX_CODE_GPOUT = 3'h4,
        GPMUX_CODE_CLK = 3'h5,
        GPMUX_CODE_CS = 3'h6,
        GPMUX_CODE_SCAN = 3'h7
    } gpmux_code_t;
    // decoded role of one pin
    typedef enum {
        GPMUX_FN_GPIN, GPMUX_FN_IRQ, GPMUX_FN_KCLK, GPMUX_FN_KDAT,
        GPMUX_FN_IOCS, GPMUX_FN_MEMCS, GPMUX_FN_LOWBAT, GPMUX_FN_RXD,
        GPMUX_FN_KEYIN, GPMUX_FN_GPOUT, GPMUX_FN_SYSCLK, GPMUX_FN_BHE,
        GPMUX_FN_CS0, GPMUX_FN_CS1, GPMUX_FN_CS2, GPMUX_FN_LCDM,
        GPMUX_FN_SCAN, GPMUX_FN_RSVD
    } gpmux_fn_t;

endpackage

// File: logic/gpmux_top.sv
// Purpose: pin function multiplexer for pins a0..a7 and b5..b7
// Assumes: avalon-mm slave, one wait state, inputs synchronous to CLK
// Notes: all outputs registered, so pin effects lag one clock
// Function
// RULE1 - all function codes reset to general input
// RULE2 - code 100 is output; odd pin high
// RULE3 - six rw mode registers at 50H-55H
// RULE4 - a6 irq: select clear irq11, set irq3
// RULE5 - a5 irq12/irq4, a4 irq13/irq5
// RULE6 - a3 irq14/irq6, a2 irq15/irq7
// RULE7 - b7 irq9/irq1, b5 irq11/irq3
// RULE8 - irq select matters only under code 001
// RULE9 - a7 and b6 code 001 is irq10
// RULE10 - a1/a0: 001 iocs16/memcs16, 010 keyboard
// RULE11 - code 010 alternate inputs per pin table
// RULE12 - 011 key return, 111 scan drive
// RULE13 - code 110 chip selects or lcd bias
// RULE14 - code 101 sysclk or bhe, else reserved
// RULE15 - reserved bits reset and read zero
// RULE16 - reserved codes act as general input
// RULE17 - codes 0xx input, 1xx drive pin
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "gpmux_cfg.svh"

module gpmux_top
(
    input wire logic CLK,
    input wire logic RST,
    // avalon-mm slave, byte address
    input wire logic [9:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // pad side, bit order a0..a7, b5, b6, b7
    input wire gpmux_pkg::gpmux_pins_t PIN_IN,
    output gpmux_pkg::gpmux_pins_t PIN_OUT,
    output gpmux_pkg::gpmux_pins_t PIN_OE_N,
    // on-chip sources that may drive a pin
    input wire logic SYSCLK_IN,
    input wire logic BHE_IN,
    input wire logic [2:0] CHIP_SELECT_IN,
    input wire logic LCD_AC_BIAS_OUTPUT_IN,
    input wire gpmux_pkg::gpmux_lines_t SCAN_DRIVE_IN,
    // on-chip sinks fed from a pin
    output gpmux_pkg::gpmux_lines_t IRQ_OUT,
    output gpmux_pkg::gpmux_lines_t KEY_RETURN_INPUT,
    output logic KBD_CLOCK_IN_OUT,
    output logic KBD_DATA_IN_OUT,
    output logic IOCS16_OUT,
    output logic MEMCS16_OUT,
    output logic SECOND_LOW_BATTERY_INPUT,
    output logic AUX_SERIAL_RECEIVE_INPUT
);
    import gpmux_pkg::*;

    // mode registers, index 0 is 50H
    logic [7:0] mode_reg [0:`GPMUX_NMODE-1];
    // general-purpose output data per pin
    gpmux_pins_t gp_out_reg;
    // bus answer registers
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    // pad and sink registers
    gpmux_pins_t pin_out_reg;
    gpmux_pins_t pin_out_next;
    gpmux_pins_t pin_oe_n_reg;
    gpmux_pins_t pin_oe_n_next;
    gpmux_lines_t irq_reg;
    gpmux_lines_t irq_next;
    gpmux_lines_t keyin_reg;
    gpmux_lines_t keyin_next;
    logic [5:0] sink_reg;
    logic [5:0] sink_next;
    // per-pin code and irq select, unpacked from mode registers
    logic [2:0] code [0:`GPMUX_NPINS-1];
    gpmux_pins_t sel;
    // bus decode
    logic req;
    logic word_ok;
    logic [7:0] idx;
    logic take_wr;

    // word index of the access; low two bits must be zero
    assign idx = ADDRESS[9:2];
    assign word_ok = (ADDRESS[1:0] == 2'h0);
    assign req = READ | WRITE;
    // write lands on the cycle waitrequest is low
    assign take_wr = WRITE & ~wait_reg & word_ok & BYTEENABLE[0];

    // writable bits of each mode register; reserved bits stay zero
    function automatic logic [7:0] wmask(input int r);
        case (r)
            0: wmask = `GPMUX_WMASK_A76;
            3: wmask = `GPMUX_WMASK_A10;
            4: wmask = `GPMUX_WMASK_B76;
            default: wmask = `GPMUX_WMASK_FULL;
        endcase
    endfunction

    // decode pin index and code into the pin's role
    function automatic gpmux_fn_t fn_of(input int p, input logic [2:0] c);
        fn_of = GPMUX_FN_RSVD;
        case (c)
            GPMUX_CODE_GPIN: fn_of = GPMUX_FN_GPIN;
            GPMUX_CODE_IRQ:
            begin
                // a1/a0 carry bus size inputs instead of irq
                if (p == 1)
                    fn_of = GPMUX_FN_IOCS; // RULE10
                else if (p == 0)
                    fn_of = GPMUX_FN_MEMCS; // RULE10
                else
                    fn_of = GPMUX_FN_IRQ;
            end
            GPMUX_CODE_ALT:
            begin
                // per-pin alternate input
                case (p)
                    7, 0: fn_of = GPMUX_FN_KCLK; // RULE11
                    6, 1: fn_of = GPMUX_FN_KDAT; // RULE11
                    5: fn_of = GPMUX_FN_IOCS; // RULE11
                    4: fn_of = GPMUX_FN_MEMCS; // RULE11
                    3, `GPMUX_PIN_B6: fn_of = GPMUX_FN_LOWBAT; // RULE11
                    default: fn_of = GPMUX_FN_RXD; // RULE11
                endcase
            end
            GPMUX_CODE_KEYIN: fn_of = GPMUX_FN_KEYIN; // RULE12
            GPMUX_CODE_GPOUT: fn_of = GPMUX_FN_GPOUT; // RULE2
            GPMUX_CODE_CLK:
            begin
                // clock or byte-high strobe, else reserved
                case (p)
                    7, 3, `GPMUX_PIN_B7: fn_of = GPMUX_FN_SYSCLK; // RULE14
                    6, 2, `GPMUX_PIN_B6: fn_of = GPMUX_FN_BHE; // RULE14
                    default: fn_of = GPMUX_FN_RSVD; // RULE14
                endcase
            end
            GPMUX_CODE_CS:
            begin
                // chip select or lcd bias, a3 reserved
                case (p)
                    7, 1, `GPMUX_PIN_B7: fn_of = GPMUX_FN_CS2; // RULE13
                    6, 0, `GPMUX_PIN_B6: fn_of = GPMUX_FN_CS1; // RULE13
                    5, `GPMUX_PIN_B5: fn_of = GPMUX_FN_CS0; // RULE13
                    4, 2: fn_of = GPMUX_FN_LCDM; // RULE13
                    default: fn_of = GPMUX_FN_RSVD; // RULE13
                endcase
            end
            GPMUX_CODE_SCAN: fn_of = GPMUX_FN_SCAN; // RULE12
            default: fn_of = GPMUX_FN_RSVD;
        endcase
    endfunction

    // irq line for a pin under code 001
    function automatic logic [3:0] irq_line(input int p, input logic s);
        case (p)
            7, `GPMUX_PIN_B6: irq_line = `GPMUX_IRQ_A7_B6; // RULE9
            6: irq_line = s ? `GPMUX_IRQ_A6_SET : `GPMUX_IRQ_A6_CLR; // RULE4
            5: irq_line = s ? `GPMUX_IRQ_A5_SET : `GPMUX_IRQ_A5_CLR; // RULE5
            4: irq_line = s ? `GPMUX_IRQ_A4_SET : `GPMUX_IRQ_A4_CLR; // RULE5
            3: irq_line = s ? `GPMUX_IRQ_A3_SET : `GPMUX_IRQ_A3_CLR; // RULE6
            2: irq_line = s ? `GPMUX_IRQ_A2_SET : `GPMUX_IRQ_A2_CLR; // RULE6
            `GPMUX_PIN_B7: irq_line = s ? `GPMUX_IRQ_B7_SET : `GPMUX_IRQ_B7_CLR; // RULE7
            `GPMUX_PIN_B5: irq_line = s ? `GPMUX_IRQ_B5_SET : `GPMUX_IRQ_B5_CLR; // RULE7
            default: irq_line = 4'h0;
        endcase
    endfunction

    // key return / scan line index of a pin
    function automatic logic [3:0] line_of(input int p);
        if (p < 8)
            line_of = 4'(p); // RULE12
        else
            line_of = 4'(p + `GPMUX_B_LINE_OFS); // RULE12
    endfunction

    // unpack per-pin fields: odd pin high field, even pin low
    always_comb
    begin
        code[7] = mode_reg[0][`GPMUX_HI_LSB +: 3]; // RULE2
        code[6] = mode_reg[0][`GPMUX_LO_LSB +: 3];
        code[5] = mode_reg[1][`GPMUX_HI_LSB +: 3];
        code[4] = mode_reg[1][`GPMUX_LO_LSB +: 3];
        code[3] = mode_reg[2][`GPMUX_HI_LSB +: 3];
        code[2] = mode_reg[2][`GPMUX_LO_LSB +: 3];
        code[1] = mode_reg[3][`GPMUX_HI_LSB +: 3];
        code[0] = mode_reg[3][`GPMUX_LO_LSB +: 3];
        code[`GPMUX_PIN_B7] = mode_reg[4][`GPMUX_HI_LSB +: 3];
        code[`GPMUX_PIN_B6] = mode_reg[4][`GPMUX_LO_LSB +: 3];
        code[`GPMUX_PIN_B5] = mode_reg[5][`GPMUX_HI_LSB +: 3];
        // irq selects; reserved positions read zero anyway
        sel = '0;
        sel[6] = mode_reg[0][`GPMUX_LO_SEL];
        sel[5] = mode_reg[1][`GPMUX_HI_SEL];
        sel[4] = mode_reg[1][`GPMUX_LO_SEL];
        sel[3] = mode_reg[2][`GPMUX_HI_SEL];
        sel[2] = mode_reg[2][`GPMUX_LO_SEL];
        sel[`GPMUX_PIN_B7] = mode_reg[4][`GPMUX_HI_SEL];
        sel[`GPMUX_PIN_B5] = mode_reg[5][`GPMUX_HI_SEL];
    end

    // route every pin by its decoded role
    always_comb
    begin
        pin_out_next = '0;
        pin_oe_n_next = '1;
        irq_next = '0;
        keyin_next = '0;
        sink_next = '0;
        for (int i = 0; i < `GPMUX_NPINS; i++)
        begin
            case (fn_of(i, code[i]))
                // input roles: driver stays off
                GPMUX_FN_IRQ:
                    irq_next[irq_line(i, sel[i])] |= PIN_IN[i]; // RULE8
                GPMUX_FN_KCLK: sink_next[0] |= PIN_IN[i]; // RULE17
                GPMUX_FN_KDAT: sink_next[1] |= PIN_IN[i]; // RULE17
                GPMUX_FN_IOCS: sink_next[2] |= PIN_IN[i]; // RULE17
                GPMUX_FN_MEMCS: sink_next[3] |= PIN_IN[i]; // RULE17
                GPMUX_FN_LOWBAT: sink_next[4] |= PIN_IN[i]; // RULE17
                GPMUX_FN_RXD: sink_next[5] |= PIN_IN[i]; // RULE17
                GPMUX_FN_KEYIN: keyin_next[line_of(i)] = PIN_IN[i]; // RULE12
                // output roles: driver on, source onto pin
                GPMUX_FN_GPOUT:
                begin
                    pin_out_next[i] = gp_out_reg[i]; // RULE2
                    pin_oe_n_next[i] = 1'b0; // RULE17
                end
                GPMUX_FN_SYSCLK:
                begin
                    pin_out_next[i] = SYSCLK_IN; // RULE14
                    pin_oe_n_next[i] = 1'b0; // RULE17
                end
                GPMUX_FN_BHE:
                begin
                    pin_out_next[i] = BHE_IN; // RULE14
                    pin_oe_n_next[i] = 1'b0; // RULE17
                end
                GPMUX_FN_CS0:
                begin
                    pin_out_next[i] = CHIP_SELECT_IN[0]; // RULE13
                    pin_oe_n_next[i] = 1'b0; // RULE17
                end
                GPMUX_FN_CS1:
                begin
                    pin_out_next[i] = CHIP_SELECT_IN[1]; // RULE13
                    pin_oe_n_next[i] = 1'b0; // RULE17
                end
                GPMUX_FN_CS2:
                begin
                    pin_out_next[i] = CHIP_SELECT_IN[2]; // RULE13
                    pin_oe_n_next[i] = 1'b0; // RULE17
                end
                GPMUX_FN_LCDM:
                begin
                    pin_out_next[i] = LCD_AC_BIAS_OUTPUT_IN; // RULE13
                    pin_oe_n_next[i] = 1'b0; // RULE17
                end
                GPMUX_FN_SCAN:
                begin
                    pin_out_next[i] = SCAN_DRIVE_IN[line_of(i)]; // RULE12
                    pin_oe_n_next[i] = 1'b0; // RULE17
                end
                // general input and reserved: nothing driven
                default: pin_oe_n_next[i] = 1'b1; // RULE16
            endcase
        end
    end

    // pad and sink registers
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            pin_out_reg <= '0;
            pin_oe_n_reg <= '1;
            irq_reg <= '0;
            keyin_reg <= '0;
            sink_reg <= '0;
        end
        else
        begin
            pin_out_reg <= pin_out_next;
            pin_oe_n_reg <= pin_oe_n_next;
            irq_reg <= irq_next;
            keyin_reg <= keyin_next;
            sink_reg <= sink_next;
        end
    end

    // mode registers: reset to general input, masked writes
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            for (int r = 0; r < `GPMUX_NMODE; r++)
                mode_reg[r] <= `GPMUX_MODE_RST; // RULE1 RULE15
        end
        else if (take_wr && idx >= `GPMUX_IDX_A76 && idx <= `GPMUX_IDX_B54)
        begin
            // reserved bits forced low on write
            for (int r = 0; r < `GPMUX_NMODE; r++)
                if (idx == `GPMUX_IDX_A76 + 8'(r))
                    mode_reg[r] <= WRITEDATA[7:0] & wmask(r); // RULE3 RULE15
        end
    end

    // general-purpose output data
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            gp_out_reg <= `GPMUX_OUT_RST;
        else if (take_wr && idx == `GPMUX_IDX_OUTA)
            gp_out_reg[7:0] <= WRITEDATA[7:0];
        else if (take_wr && idx == `GPMUX_IDX_OUTB)
            gp_out_reg[10:8] <= WRITEDATA[7:`GPMUX_B_DATA_LSB];
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_next = 32'h0;
        if (word_ok)
        begin
            if (idx >= `GPMUX_IDX_A76 && idx <= `GPMUX_IDX_B54)
                rdata_next[7:0] = mode_reg[3'(idx - `GPMUX_IDX_A76)]; // RULE3
            else if (idx == `GPMUX_IDX_OUTA)
                rdata_next[7:0] = gp_out_reg[7:0];
            else if (idx == `GPMUX_IDX_OUTB)
                rdata_next[7:`GPMUX_B_DATA_LSB] = gp_out_reg[10:8];
            else if (idx == `GPMUX_IDX_INA)
                rdata_next[7:0] = PIN_IN[7:0];
            else if (idx == `GPMUX_IDX_INB)
                rdata_next[7:`GPMUX_B_DATA_LSB] = PIN_IN[10:8];
        end
    end

    // one wait state: high on first cycle of a request, low on second
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            wait_reg <= 1'b1;
        else
            wait_reg <= ~(req & wait_reg);
    end

    // read data captured during the wait cycle
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            rdata_reg <= 32'h0;
        else if (READ && wait_reg)
            rdata_reg <= rdata_next;
    end

    // outputs straight from flops
    assign READDATA = rdata_reg;
    assign WAITREQUEST = wait_reg;
    assign PIN_OUT = pin_out_reg;
    assign PIN_OE_N = pin_oe_n_reg;
    assign IRQ_OUT = irq_reg;
    assign KEY_RETURN_INPUT = keyin_reg;
    assign KBD_CLOCK_IN_OUT = sink_reg[0];
    assign KBD_DATA_IN_OUT = sink_reg[1];
    assign IOCS16_OUT = sink_reg[2];
    assign MEMCS16_OUT = sink_reg[3];
    assign SECOND_LOW_BATTERY_INPUT = sink_reg[4];
    assign AUX_SERIAL_RECEIVE_INPUT = sink_reg[5];

endmodule // gpmux_top

// File: test/gpmux_pads.sv
// Purpose: external devices on the multiplexed pins
// Assumes: a device drives its pin only while the chip does not
// Notes: pad level is resolved here and fed back to the chip
`timescale 1ns/1ps
module gpmux_pads
(
    input wire gpmux_pkg::gpmux_pins_t pin_out,
    input wire gpmux_pkg::gpmux_pins_t pin_oe_n,
    input wire gpmux_pkg::gpmux_pins_t ext_drive,
    output gpmux_pkg::gpmux_pins_t pad
);
    import gpmux_pkg::*;
    // chip value where it drives, device value elsewhere
    assign pad = (~pin_oe_n & pin_out) | (pin_oe_n & ext_drive);
endmodule // gpmux_pads

// File: test/gpmux_top_checker.sv
// Purpose: port assertions for the pin function multiplexer
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to gpmux_top below the module
`timescale 1ns/1ps
module gpmux_top_checker
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] READDATA,
    input wire logic WAITREQUEST,
    input wire gpmux_pkg::gpmux_pins_t PIN_IN,
    input wire gpmux_pkg::gpmux_pins_t PIN_OE_N,
    input wire gpmux_pkg::gpmux_lines_t IRQ_OUT,
    input wire gpmux_pkg::gpmux_lines_t KEY_RETURN_INPUT
);
    import gpmux_pkg::*;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    gpmux_pins_t pin_last_reg; // pad value seen one edge earlier
    // delayed copy of the pads for one-cycle sink checks
    always_ff @(posedge CLK)
    begin
        pin_last_reg <= PIN_IN;
    end
    // slave answers within two edges
    sequence answer_s;
        ##[1:2] !WAITREQUEST;
    endsequence
    wait_pulse_a: assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("wait request low for more than one cycle");
    req_answer_a: assert property ((READ || WRITE) && WAITREQUEST |-> answer_s)
        else $error("request not answered in time");
    idle_wait_a: assert property (!(READ || WRITE) && !$past(READ || WRITE) |-> WAITREQUEST)
        else $error("wait request low while idle");
    rd_upper_a: assert property (READDATA[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    irq_unused_a: assert property (IRQ_OUT[0] == 1'b0 && IRQ_OUT[2] == 1'b0 && IRQ_OUT[8] == 1'b0)
        else $error("unrouted interrupt line active");
    key_gap_a: assert property (KEY_RETURN_INPUT[12:8] == 5'h00)
        else $error("unused key return line active");
    key_follow_a: assert property ((KEY_RETURN_INPUT[7:0] & ~pin_last_reg[7:0]) == 8'h00
        && (KEY_RETURN_INPUT[15:13] & ~pin_last_reg[10:8]) == 3'h0)
        else $error("key return high without its pin high");
    irq10_src_a: assert property (IRQ_OUT[10] |-> pin_last_reg[7] || pin_last_reg[9])
        else $error("irq10 high without a source pin");
    irq9_src_a: assert property (IRQ_OUT[9] |-> pin_last_reg[10])
        else $error("irq9 high without its source pin");
    drive_excl_a: assert property ((~PIN_OE_N[7:0] & KEY_RETURN_INPUT[7:0]) == 8'h00)
        else $error("driven pin also feeds a key return");
    rst_input_a: assert property ($fell(RST) |-> (&PIN_OE_N) ##1 (&PIN_OE_N))
        else $error("pin driven right after reset");
endmodule // gpmux_top_checker

bind gpmux_top gpmux_top_checker u_checker
(
    .CLK(CLK),
    .RST(RST),
    .READ(READ),
    .WRITE(WRITE),
    .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST),
    .PIN_IN(PIN_IN),
    .PIN_OE_N(PIN_OE_N),
    .IRQ_OUT(IRQ_OUT),
    .KEY_RETURN_INPUT(KEY_RETURN_INPUT)
);

// File: test/tb_gpio_pin_function_mux.sv
// Purpose: self-checking bench for the pin function multiplexer
// Assumes: one wait state bus, outputs lag one clock
// Notes: pad order a0..a7, b5, b6, b7
`timescale 1ns/1ps
module tb_gpio_pin_function_mux;
    import gpmux_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [9:0] ADDRESS = 10'h000;
    logic READ = 1'b0;
    logic WRITE = 1'b0;
    logic [31:0] WRITEDATA = 32'h00000000;
    logic [31:0] READDATA;
    logic WAITREQUEST;
    gpmux_pins_t PIN_IN;
    gpmux_pins_t PIN_OUT;
    gpmux_pins_t PIN_OE_N;
    gpmux_pins_t ext_drive = 11'h000; // device side pad values
    logic SYSCLK_IN = 1'b0;
    logic BHE_IN = 1'b0;
    logic [2:0] CHIP_SELECT_IN = 3'h0;
    logic LCD_AC_BIAS_OUTPUT_IN = 1'b0;
    gpmux_lines_t SCAN_DRIVE_IN = 16'ha0c3;
    gpmux_lines_t IRQ_OUT;
    gpmux_lines_t KEY_RETURN_INPUT;
    logic [5:0] sinks; // aux, low battery, memcs, iocs, kdat, kclk
    int miscompares = 0;
    int n_checks = 0;
    logic [7:0] v;
    logic [23:0] e;
    logic [21:0] exp_v;
    logic [7:0] masks [6] = '{8'h7f, 8'hff, 8'hff, 8'h77, 8'hf7, 8'hff};
    // reg, value, pin, kind (0 irq, 1 sink), line
    logic [23:0] tbl [29] = '{24'h01070a, 24'h00160b, 24'h009603, 24'h11050c,
        24'h190504, 24'h10140d, 24'h109405, 24'h21030e, 24'h290306, 24'h20120f,
        24'h209207, 24'h410a09, 24'h490a01, 24'h40190a, 24'h51080b, 24'h590803,
        24'h022710, 24'h002611, 24'h122512, 24'h102413, 24'h222314, 24'h202215,
        24'h311112, 24'h301013, 24'h321111, 24'h302010, 24'h420a15, 24'h402914,
        24'h520815};
    logic AUX_SERIAL_RECEIVE_INPUT;
    logic SECOND_LOW_BATTERY_INPUT;
    logic MEMCS16_OUT;
    logic IOCS16_OUT;
    logic KBD_DATA_IN_OUT;
    logic KBD_CLOCK_IN_OUT;
    assign sinks = {AUX_SERIAL_RECEIVE_INPUT, SECOND_LOW_BATTERY_INPUT, MEMCS16_OUT,
        IOCS16_OUT, KBD_DATA_IN_OUT, KBD_CLOCK_IN_OUT};
    gpmux_top DUT
    (
        .CLK(CLK),
        .RST(RST),
        .ADDRESS(ADDRESS),
        .READ(READ),
        .WRITE(WRITE),
        .WRITEDATA(WRITEDATA),
        .BYTEENABLE(4'hf),
        .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST),
        .PIN_IN(PIN_IN),
        .PIN_OUT(PIN_OUT),
        .PIN_OE_N(PIN_OE_N),
        .SYSCLK_IN(SYSCLK_IN),
        .BHE_IN(BHE_IN),
        .CHIP_SELECT_IN(CHIP_SELECT_IN),
        .LCD_AC_BIAS_OUTPUT_IN(LCD_AC_BIAS_OUTPUT_IN),
        .SCAN_DRIVE_IN(SCAN_DRIVE_IN),
        .IRQ_OUT(IRQ_OUT),
        .KEY_RETURN_INPUT(KEY_RETURN_INPUT),
        .KBD_CLOCK_IN_OUT(KBD_CLOCK_IN_OUT),
        .KBD_DATA_IN_OUT(KBD_DATA_IN_OUT),
        .IOCS16_OUT(IOCS16_OUT),
        .MEMCS16_OUT(MEMCS16_OUT),
        .SECOND_LOW_BATTERY_INPUT(SECOND_LOW_BATTERY_INPUT),
        .AUX_SERIAL_RECEIVE_INPUT(AUX_SERIAL_RECEIVE_INPUT)
    );
    gpmux_pads PADS
    (
        .pin_out(PIN_OUT),
        .pin_oe_n(PIN_OE_N),
        .ext_drive(ext_drive),
        .pad(PIN_IN)
    );
    // 50 MHz clock
    initial
    begin
        forever #10 CLK = ~CLK;
    end
    // compare and count
    task automatic check(input string what, input logic [37:0] seen, input logic [37:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one avalon access, held until wait request is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
        output logic [7:0] rd);
        @(posedge CLK);
        ADDRESS <= {idx, 2'b00};
        WRITEDATA <= {24'h000000, wd};
        WRITE <= wr;
        READ <= !wr;
        // only the watchdog ends a wait that never comes
        do
        begin
            @(posedge CLK);
        end
        while (WAITREQUEST !== 1'b0);
        rd = READDATA[7:0];
        WRITE <= 1'b0;
        READ <= 1'b0;
    endtask
    // same value into all six mode registers
    task automatic set_all(input logic [7:0] val);
        for (int i = 0; i < 6; i++)
            bus(1'b1, 8'(8'h50 + i), val, v);
    endtask
    // register change reaches the pins one edge later; settle waits two
    task automatic settle;
        repeat (2) @(posedge CLK);
        @(negedge CLK);
    endtask
    // single exit point
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (20000) @(posedge CLK);
        miscompares++;
        wrap_up;
    end
    // main sequence
    initial
    begin
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        @(negedge CLK);
        check("oe after reset", PIN_OE_N, 11'h7ff);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, 8'(8'h50 + i), 8'h00, v);
            check("mode reset", v, 8'h00);
            bus(1'b1, 8'(8'h50 + i), 8'hff, v);
            bus(1'b0, 8'(8'h50 + i), 8'h00, v);
            check("mode rw", v, masks[i]);
        end
        bus(1'b0, 8'h70, 8'h00, v);
        check("unmapped", v, 8'h00);
        $display("test registers done");
        bus(1'b1, 8'h60, 8'ha5, v);
        bus(1'b1, 8'h61, 8'ha0, v);
        set_all(8'h44);
        settle;
        check("gp out", PIN_OUT, 11'h5a5);
        check("gp oe", PIN_OE_N, 11'h000);
        set_all(8'h77);
        settle;
        check("scan", PIN_OUT, 11'h5c3);
        set_all(8'h33);
        ext_drive <= 11'h2d6;
        settle;
        check("key ret", KEY_RETURN_INPUT, 16'h40d6);
        check("key irq", IRQ_OUT, 16'h0000);
        check("key oe", PIN_OE_N, 11'h7ff);
        bus(1'b0, 8'h60, 8'h00, v);
        check("gp data", v, 8'ha5);
        bus(1'b0, 8'h62, 8'h00, v);
        check("pin level", v, 8'hd6);
        CHIP_SELECT_IN <= 3'b101;
        set_all(8'h66);
        settle;
        check("cs oe", PIN_OE_N, 11'h008);
        check("cs out", PIN_OUT & 11'h7f7, 11'h5a2);
        @(posedge CLK);
        CHIP_SELECT_IN <= 3'b010;
        LCD_AC_BIAS_OUTPUT_IN <= 1'b1;
        settle;
        check("cs out inv", PIN_OUT & 11'h7f7, 11'h255);
        @(posedge CLK);
        SYSCLK_IN <= 1'b1;
        set_all(8'h55);
        settle;
        check("clk oe", PIN_OE_N, 11'h133);
        check("clk out", PIN_OUT & 11'h6cc, 11'h488);
        // swap sources so clock and strobe pins show opposite levels
        @(posedge CLK);
        SYSCLK_IN <= 1'b0;
        BHE_IN <= 1'b1;
        settle;
        check("bhe out", PIN_OUT & 11'h6cc, 11'h244);
        $display("test pin outputs done");
        set_all(8'h00);
        for (int i = 0; i < 29; i++)
        begin
            e = tbl[i];
            bus(1'b1, {4'h5, e[23:20]}, e[19:12], v);
            ext_drive <= 11'(1 << e[11:8]);
            settle;
            exp_v = e[4] ? {6'(1 << e[3:0]), 16'h0000} : {6'h00, 16'(1 << e[3:0])};
            check("route", {sinks, IRQ_OUT}, exp_v);
            bus(1'b1, {4'h5, e[23:20]}, e[19:12] & 8'h88, v);
            settle;
            check("route off", {sinks, IRQ_OUT}, 22'h000000);
        end
        $display("test routing done");
        wrap_up;
    end
endmodule // tb_gpio_pin_function_mux
